// File: rtl/pcd_top.sv
`timescale 1ns/1ps
// Pulse command decoder with an AXI4-Lite register slave.
module pcd_top
   import pcd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic slow_pulse,
   input wire logic slow_dir,
   input wire logic fast_pulse,
   input wire logic fast_dir,
   output logic step_fwd,
   output logic step_rev,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [7:0] input_pulse_setting;
   logic [7:0] next_setting;
   logic [31:0] position_count;
   logic [31:0] next_count;
   logic line_a;
   logic line_b;
   logic prev_a;
   logic prev_b;
   logic aw_held;
   logic next_aw_held;
   logic w_held;
   logic next_w_held;
   logic [3:0] aw_addr;
   logic [3:0] next_aw_addr;
   logic [31:0] w_data;
   logic [31:0] next_w_data;
   logic w_lane0;
   logic next_w_lane0;
   logic [1:0] bresp;
   logic [1:0] next_bresp;
   logic bvalid;
   logic next_bvalid;
   pcd_bus_e rd_state;
   pcd_bus_e next_rd_state;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [1:0] rresp;
   logic [1:0] next_rresp;
   logic do_write;

   // One address decoder serves both paths, so reads and writes cannot disagree on the map.
   function automatic logic pcd_hit(input logic [3:0] addr, input logic [3:0] reg_addr);
      pcd_hit = (addr[3:2] == reg_addr[3:2]);
   endfunction

   pcd_sampler u_sampler (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .use_fast(input_pulse_setting[PCD_SRC_BIT]),
      .slow_a(slow_pulse),
      .slow_b(slow_dir),
      .fast_a(fast_pulse),
      .fast_b(fast_dir),
      .line_a(line_a),
      .line_b(line_b),
      .prev_a(prev_a),
      .prev_b(prev_b)
   );

   pcd_decoder u_decoder (
      .setting(input_pulse_setting[4:0]),
      .line_a(line_a),
      .line_b(line_b),
      .prev_a(prev_a),
      .prev_b(prev_b),
      .step_fwd(step_fwd),
      .step_rev(step_rev)
   );

   // Ready only while the channel holding register is empty and no response is pending.
   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready = !w_held && !bvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = (rd_state == PCD_IDLE);
   assign s_axi_rvalid = (rd_state == PCD_RESP);
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign do_write = aw_held && w_held && !bvalid;

   // Write path: address and data may arrive in either order; the write commits when both are held.
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_setting = input_pulse_setting;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_lane0 = s_axi_wstrb[0];
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         if (pcd_hit(aw_addr, PCD_ADDR_SETTING)) begin
            next_bresp = PCD_RESP_OKAY;
            // RULE6: whole value write
            if (w_lane0) begin
               next_setting = w_data[7:0] & PCD_SETTING_MASK;
            end
         end else if (pcd_hit(aw_addr, PCD_ADDR_STATUS) || pcd_hit(aw_addr, PCD_ADDR_COUNT)) begin
            next_bresp = PCD_RESP_OKAY;
         end else begin
            next_bresp = PCD_RESP_SLVERR;
         end
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // Read path answers one cycle after the address is taken.
   always_comb begin
      next_rd_state = rd_state;
      next_rdata = rdata;
      next_rresp = rresp;
      case (rd_state)
         PCD_IDLE: begin
            if (s_axi_arvalid) begin
               next_rd_state = PCD_RESP;
               next_rresp = PCD_RESP_OKAY;
               if (pcd_hit(s_axi_araddr, PCD_ADDR_SETTING)) begin
                  next_rdata = {24'h000000, input_pulse_setting};
               end else if (pcd_hit(s_axi_araddr, PCD_ADDR_STATUS)) begin
                  next_rdata = {28'h0000000, step_rev, step_fwd, prev_b, prev_a};
               end else if (pcd_hit(s_axi_araddr, PCD_ADDR_COUNT)) begin
                  next_rdata = position_count;
               end else begin
                  next_rdata = 32'h00000000;
                  next_rresp = PCD_RESP_SLVERR;
               end
            end
         end
         PCD_RESP: begin
            if (s_axi_rready) begin
               next_rd_state = PCD_IDLE;
            end
         end
         default: begin
            next_rd_state = PCD_IDLE;
         end
      endcase
   end

   // Signed position count follows the decoded steps; it wraps on overflow.
   always_comb begin
      next_count = position_count;
      if (step_fwd) begin
         next_count = position_count + 32'h00000001;
      end else if (step_rev) begin
         next_count = position_count - 32'h00000001;
      end
   end

   // All state freezes while the clock enable is low, bus included.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         input_pulse_setting <= PCD_SETTING_RESET;
         position_count <= PCD_COUNT_RESET;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= PCD_RESP_OKAY;
         rd_state <= PCD_IDLE;
         rdata <= 32'h00000000;
         rresp <= PCD_RESP_OKAY;
      end else if (ce) begin
         input_pulse_setting <= next_setting;
         position_count <= next_count;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rd_state <= next_rd_state;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end
endmodule

// File: rtl/pcd_pkg.sv
// Summary of operation
// RULE1: Bits 1:0 pick format: 01 step+direction, 10 separate lines, 11 quadrature.
// RULE2: The controller drives exactly one of the three supported formats.
// RULE3: Bit 2 swaps forward and reverse in every format.
// RULE4: Separate lines: pulses on forward line count forward, reverse line reverse.
// RULE5: Bit 3 picks the counting edge: 0 falling, 1 rising.
// RULE6: Software may write the whole setting as one combined value.
// RULE7: Bit 4 picks low-speed inputs (0) or high-speed differential inputs (1).
// RULE8: Direction closed means forward; quadrature A leading B means forward; bit 2 inverts.
package pcd_pkg;
   localparam logic [7:0] PCD_SETTING_RESET = 8'h01;
   localparam int PCD_FMT_LSB = 0;
   localparam int PCD_DIR_BIT = 2;
   localparam int PCD_EDGE_BIT = 3;
   localparam int PCD_SRC_BIT = 4;
   localparam logic [7:0] PCD_SETTING_MASK = 8'h1f;
   localparam logic [3:0] PCD_ADDR_SETTING = 4'h0;
   localparam logic [3:0] PCD_ADDR_STATUS = 4'h4;
   localparam logic [3:0] PCD_ADDR_COUNT = 4'h8;
   localparam logic [1:0] PCD_FMT_STEP_DIR = 2'h1;
   localparam logic [1:0] PCD_FMT_SEPARATE = 2'h2;
   localparam logic [1:0] PCD_FMT_QUAD = 2'h3;
   localparam logic [1:0] PCD_RESP_OKAY = 2'h0;
   localparam logic [1:0] PCD_RESP_SLVERR = 2'h2;
   localparam logic [31:0] PCD_COUNT_RESET = 32'h0;

   typedef enum logic [1:0] {
      PCD_IDLE = 2'b00,
      PCD_RESP = 2'b01,
      PCD_BUSY = 2'b11
   } pcd_bus_e;

   // Selects the configured counting edge from previous and current line levels.
   function automatic logic pcd_edge(input logic prev, input logic cur, input logic rising);
      pcd_edge = rising ? (!prev && cur) : (prev && !cur);
   endfunction
endpackage

// File: rtl/pcd_sampler.sv
`timescale 1ns/1ps
// Registers the selected source pair so edges are judged against a stable previous level.
module pcd_sampler
   import pcd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic use_fast,
   input wire logic slow_a,
   input wire logic slow_b,
   input wire logic fast_a,
   input wire logic fast_b,
   output logic line_a,
   output logic line_b,
   output logic prev_a,
   output logic prev_b
);
   logic next_line_a;
   logic next_line_b;

   // Source choice; switching sources may produce one spurious edge.
   // RULE7: source select mux
   always_comb begin
      next_line_a = use_fast ? fast_a : slow_a;
      next_line_b = use_fast ? fast_b : slow_b;
   end

   // Two stages give current and previous level for edge detection.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_a <= 1'b0;
         line_b <= 1'b0;
         prev_a <= 1'b0;
         prev_b <= 1'b0;
      end else if (ce) begin
         line_a <= next_line_a;
         line_b <= next_line_b;
         prev_a <= line_a;
         prev_b <= line_b;
      end
   end
endmodule

// File: rtl/pcd_decoder.sv
`timescale 1ns/1ps
// Turns sampled line levels into one-cycle forward and reverse step pulses.
module pcd_decoder
   import pcd_pkg::*;
(
   input wire logic [4:0] setting,
   input wire logic line_a,
   input wire logic line_b,
   input wire logic prev_a,
   input wire logic prev_b,
   output logic step_fwd,
   output logic step_rev
);
   logic edge_a;
   logic edge_b;
   logic raw_fwd;
   logic raw_rev;

   // Format decode and direction; the controller keeps to one format.
   always_comb begin
      // RULE5: counting edge select
      edge_a = pcd_edge(prev_a, line_a, setting[PCD_EDGE_BIT]);
      edge_b = pcd_edge(prev_b, line_b, setting[PCD_EDGE_BIT]);
      raw_fwd = 1'b0;
      raw_rev = 1'b0;
      // RULE1: format decode
      case (setting[PCD_FMT_LSB +: 2])
         PCD_FMT_STEP_DIR: begin
            // RULE8: closed means forward
            raw_fwd = edge_a && line_b;
            raw_rev = edge_a && !line_b;
         end
         PCD_FMT_SEPARATE: begin
            // RULE4: separate line counting
            raw_fwd = edge_a && !line_b;
            raw_rev = edge_b && !line_a;
         end
         PCD_FMT_QUAD: begin
            // RULE8: A leads B forward
            raw_fwd = (edge_a && (line_a != line_b)) || (edge_b && (line_a == line_b)); // Holds for either edge.
            raw_rev = (edge_a && (line_a == line_b)) || (edge_b && (line_a != line_b));
         end
         default: begin
            raw_fwd = 1'b0;
            raw_rev = 1'b0;
         end
      endcase
      // RULE3: direction swap
      step_fwd = setting[PCD_DIR_BIT] ? raw_rev : raw_fwd;
      step_rev = setting[PCD_DIR_BIT] ? raw_fwd : raw_rev;
   end
endmodule

// File: testbench/pcd_top_sva.sv
`timescale 1ns/1ps
// Shadows the setting from bus writes and predicts each step from its own line samples.
module pcd_top_sva
   import pcd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic slow_pulse,
   input wire logic slow_dir,
   input wire logic fast_pulse,
   input wire logic fast_dir,
   input wire logic step_fwd,
   input wire logic step_rev,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] wa;
   logic [4:0] wd, cfg;
   logic [2:0] quiet;
   logic a1, a2, b1, b2, ea, eb, rf, rr, xf, xr, q;
   // The design commits before its response, so predictions wait until the bus has been quiet.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= PCD_SETTING_RESET[4:0];
         quiet <= 3'h0;
         {a1, a2, b1, b2} <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[4:0];
         if (s_axi_bvalid && s_axi_bready && wa == PCD_ADDR_SETTING) cfg <= wd;
         quiet <= (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid) ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
         a1 <= cfg[4] ? fast_pulse : slow_pulse;
         b1 <= cfg[4] ? fast_dir : slow_dir;
         a2 <= a1;
         b2 <= b1;
      end
   end
   // Expected step from the edge choice, the format and the sense bit.
   always_comb begin
      ea = cfg[3] ? (a1 && !a2) : (a2 && !a1);
      eb = cfg[3] ? (b1 && !b2) : (b2 && !b1);
      rf = 1'b0;
      rr = 1'b0;
      case (cfg[1:0])
         PCD_FMT_STEP_DIR: begin
            rf = ea && b1;
            rr = ea && !b1;
         end
         PCD_FMT_SEPARATE: begin
            rf = ea && !b1;
            rr = eb && !a1;
         end
         PCD_FMT_QUAD: begin
            rf = (ea && (a1 ^ b1)) || (eb && (a1 == b1));
            rr = (ea && (a1 == b1)) || (eb && (a1 ^ b1));
         end
         default: ;
      endcase
      xf = cfg[2] ? rr : rf;
      xr = cfg[2] ? rf : rr;
      q = quiet > 3'h3;
   end
   sequence s_sel_still;
      q && (cfg[4] ? $stable({fast_pulse, fast_dir}) : $stable({slow_pulse, slow_dir}));
   endsequence
   sequence s_a_leads;
      q && cfg[1:0] == PCD_FMT_QUAD && !cfg[2] && ea && a1 && !b1;
   endsequence
   property p_fwd; q && xf |-> step_fwd; endproperty
   property p_rev; q && xr |-> step_rev; endproperty
   property p_nof; q && !xf |-> !step_fwd; endproperty
   property p_nor; q && !xr |-> !step_rev; endproperty
   property p_swap; q && cfg[2] && rf |-> step_rev && !step_fwd; endproperty
   property p_sep; q && cfg[1:0] == PCD_FMT_SEPARATE && !cfg[2] && eb && !a1 |-> step_rev; endproperty
   property p_src; s_sel_still |=> !step_fwd && !step_rev; endproperty
   property p_quad; s_a_leads |-> step_fwd; endproperty
   a_fwd: assert property (p_fwd) else $error("forward step missing");
   a_rev: assert property (p_rev) else $error("reverse step missing");
   a_nof: assert property (p_nof) else $error("stray forward step");
   a_nor: assert property (p_nor) else $error("stray reverse step");
   a_swap: assert property (p_swap) else $error("sense bit not swapping");
   a_sep: assert property (p_sep) else $error("second line not reverse");
   a_src: assert property (p_src) else $error("step from unused source");
   a_quad: assert property (p_quad) else $error("A leading B not forward");
endmodule
bind pcd_top pcd_top_sva pcd_top_sva_i (.aclk, .aresetn, .ce, .slow_pulse, .slow_dir, .fast_pulse, .fast_dir,
   .step_fwd, .step_rev, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready);

// File: testbench/pcd_ctrl_model.sv
`timescale 1ns/1ps
// Motion controller stand-in: drives the chosen pair and scribbles on the other one.
module pcd_ctrl_model (
   input wire logic aclk,
   input wire logic fast,
   output logic slow_pulse,
   output logic slow_dir,
   output logic fast_pulse,
   output logic fast_dir
);
   logic a = 1'b0, b = 1'b0, na = 1'b0, nb = 1'b0, noise = 1'b0;
   // Noise on the idle pair makes a wrong source choice show up as stray steps.
   always @(posedge aclk) begin
      na <= noise & 1'($urandom());
      nb <= noise & 1'($urandom());
   end
   assign slow_pulse = fast ? na : a;
   assign slow_dir = fast ? nb : b;
   assign fast_pulse = fast ? a : na;
   assign fast_dir = fast ? b : nb;
   task automatic send(input logic [1:0] fmt, input logic rev);
      logic [7:0] s;
      int k;
      s = (fmt == 2'h3) ? (rev ? 8'h78 : 8'hb4) : (fmt == 2'h2) ? (rev ? 8'h40 : 8'h80) : (rev ? 8'h20 : 8'h74);
      noise <= 1'b1;
      for (k = 0; k < 4; k++) begin
         {a, b} <= s[7:6];
         s = s << 2;
         repeat (2) @(posedge aclk);
      end
      noise <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
   import pcd_pkg::*;
   logic aclk, aresetn, ce, slow_pulse, slow_dir, fast_pulse, fast_dir, step_fwd, step_rev, fast, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, e2;
   logic [33:0] e34;
   logic [4:0] cfg;
   logic [1:0] sq[$], bq[$];
   logic [33:0] rq[$];
   int errors = 0, check_count = 0, cnt = 0, i, k, n;
   pcd_top pcd_top_i (.aclk, .aresetn, .ce, .slow_pulse, .slow_dir, .fast_pulse, .fast_dir, .step_fwd,
      .step_rev, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pcd_ctrl_model pcd_ctrl_model_i (.aclk, .fast, .slow_pulse, .slow_dir, .fast_pulse, .fast_dir);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic finish_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Each channel is released at the edge that takes it; the response is awaited with ready held.
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
      bq.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [33:0] ex);
      rq.push_back(ex);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Results are matched against the oldest note as they appear.
   always @(posedge aclk) begin
      if ((step_fwd | step_rev) !== 1'b0) begin
         e2 = sq.size() ? sq.pop_front() : 2'h0;
         `CHK("step", e2, {step_rev, step_fwd})
      end
      if (s_axi_bvalid && s_axi_bready) begin
         e2 = bq.pop_front();
         `CHK("bresp", e2, s_axi_bresp)
      end
      if (s_axi_rvalid && s_axi_rready) begin
         e34 = rq.pop_front();
         `CHK("read", e34, {s_axi_rresp, s_axi_rdata})
      end
   end
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h3316));
      {aresetn, fast, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      ce = 1'b1;
      s_axi_wstrb = 4'h1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(PCD_ADDR_SETTING, {PCD_RESP_OKAY, 24'h0, PCD_SETTING_RESET});
      rd(4'hc, {PCD_RESP_SLVERR, 32'h0});
      wr(4'hc, 32'h0, PCD_RESP_SLVERR);
      // Every format, sense, edge and source, written as one value with junk above the fields.
      for (i = 0; i < 24; i++) begin
         cfg = {i[0], i[1], i[2], 2'(i / 8 + 1)};
         d = ($urandom() & 32'hffffffe0) | {27'h0, cfg};
         wr(PCD_ADDR_SETTING, d, PCD_RESP_OKAY);
         rd(PCD_ADDR_SETTING, {PCD_RESP_OKAY, 27'h0, cfg});
         fast <= cfg[4];
         n = $urandom_range(3, 1);
         for (k = 0; k < n; k++) begin
            r = 1'($urandom());
            repeat (cfg[1:0] == PCD_FMT_QUAD ? 2 : 1) sq.push_back((r ^ cfg[2]) ? 2'h2 : 2'h1);
            cnt += ((r ^ cfg[2]) ? -1 : 1) * (cfg[1:0] == PCD_FMT_QUAD ? 2 : 1);
            pcd_ctrl_model_i.send(cfg[1:0], r);
         end
      end
      // A burst while the clock enable is low must leave no step and no count behind.
      ce <= 1'b0;
      pcd_ctrl_model_i.send(PCD_FMT_QUAD, 1'b0);
      ce <= 1'b1;
      wr(PCD_ADDR_SETTING, 32'h00000000, PCD_RESP_OKAY);
      rd(PCD_ADDR_SETTING, {PCD_RESP_OKAY, 32'h00000000});
      fast <= 1'b0;
      pcd_ctrl_model_i.send(PCD_FMT_STEP_DIR, 1'b0);
      repeat (4) @(posedge aclk);
      wr(PCD_ADDR_COUNT, 32'h5a5a5a5a, PCD_RESP_OKAY);
      rd(PCD_ADDR_COUNT, {PCD_RESP_OKAY, 32'(cnt)});
      rd(PCD_ADDR_STATUS, {PCD_RESP_OKAY, 32'h00000000});
      `CHK("pending", 32'h0, 32'(sq.size()))
      finish_test();
   end
endmodule
